// *** design/supervisor_pkg.sv ***
// How it works
// RQ1 - Low supply asserts reset on both outputs
// RQ2 - Supply recovery holds reset for full timeout
// RQ3 - Manual low holds reset, plus 140ms after
// RQ4 - Manual input debounced internally
// RQ5 - No kick toggle for 1.6s forces reset
// RQ6 - Reset or kick edge clears watchdog counter
// RQ7 - Manual reset assertion clears watchdog counter
// RQ8 - Counter frozen at zero during reset
// RQ9 - Kick pulses of 50ns count as toggles
// RQ10 - Weak driver low 7/8, high 1/8
// RQ11 - Host keeps kick low, pulses early
// RQ12 - Host sets and clears kick separately
// RQ13 - Active-high output complements active-low output
// RQ14 - Open-drain style only pulls low
// RQ15 - Timeouts counted in clock cycles
// RQ16 - Build parameters select variant features
package supervisor_pkg;
  localparam int unsigned CLK_HZ            = 20_000_000;
  localparam int unsigned RESET_HOLD_MS     = 140;
  localparam int unsigned WDOG_TIMEOUT_MS   = 1600;
  localparam int unsigned DEBOUNCE_US       = 1;
  localparam int unsigned KICK_PULSE_NS     = 50;
  localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
  // Least times round up
  localparam int unsigned RESET_HOLD_CYC    = RESET_HOLD_MS * (CLK_HZ / 1000);
  localparam int unsigned WDOG_TIMEOUT_CYC  = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC_RAW  = (DEBOUNCE_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned DEBOUNCE_CYC      = (DEBOUNCE_CYC_RAW < 1) ? 1 : DEBOUNCE_CYC_RAW;
  localparam int unsigned KICK_PULSE_CYC    = (KICK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W             = 32;
  localparam int unsigned DEB_W             = 8;
  localparam int unsigned WD_EIGHTHS        = 8;
  localparam int unsigned WD_LOW_EIGHTHS    = 7;
  typedef logic [CNT_W-1:0] count_t;
  typedef logic [DEB_W-1:0] deb_t;
  typedef enum logic [1:0] {st_power, st_hold, st_run} sup_state_e;
endpackage : supervisor_pkg

// *** design/input_debounce.sv ***
`timescale 1ns/1ns
module input_debounce
  import supervisor_pkg::*;
#(
  parameter deb_t STABLE_CYC = deb_t'(DEBOUNCE_CYC)
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Raw and filtered level
  input  wire logic raw_in,
  output logic      clean_out
);
  import supervisor_pkg::*;
  deb_t cnt_reg;
  logic clean_reg;
  wire  differs  = raw_in != clean_reg;
  wire  settled  = differs && (cnt_reg >= STABLE_CYC - deb_t'(1));
  wire  deb_t cnt_next = differs ? (settled ? '0 : cnt_reg + deb_t'(1)) : '0;
  // Level must stand STABLE_CYC cycles before it passes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt_reg   <= '0;
      clean_reg <= 1'b1;
    end else begin
      cnt_reg <= cnt_next; // [RQ4]
      if (settled) begin
        clean_reg <= raw_in; // [RQ4]
      end
    end
  end
  assign clean_out = clean_reg;
endmodule : input_debounce

// *** design/supervisor_reset_watchdog.sv ***
`timescale 1ns/1ns
module supervisor_reset_watchdog
  import supervisor_pkg::*;
#(
  parameter bit     HAS_WATCHDOG     = 1'b1,
  parameter bit     HAS_MANUAL       = 1'b1,
  parameter bit     HAS_ACTIVE_HIGH  = 1'b1,
  parameter bit     OPEN_DRAIN       = 1'b0,
  parameter count_t RESET_HOLD_CYCLES = count_t'(RESET_HOLD_CYC),
  parameter count_t WDOG_CYCLES       = count_t'(WDOG_TIMEOUT_CYC)
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // Supply monitor
  input  wire logic supply_low,
  // Manual reset
  input  wire logic manual_reset_n,
  // Watchdog kick pin
  input  wire logic watchdog_kick_in,
  output logic      kick_weak_out,
  output logic      kick_weak_oe_n,
  // Reset outputs
  output logic      reset_n_out,
  output logic      reset_n_oe_n,
  output logic      reset_out
);
  import supervisor_pkg::*;

  // Sequencer state and timers
  sup_state_e state_reg;
  sup_state_e state_next;
  count_t     hold_reg;
  count_t     hold_next;
  count_t     wd_reg;
  count_t     wd_next;
  count_t     weak_edge;

  // Edge detector history
  logic       kick_d_reg;
  logic       man_d_reg;

  // Output flops and their next values
  logic       weak_reg;
  logic       weak_next;
  logic       weak_oe_reg;
  logic       rst_n_reg;
  logic       rst_n_oe_reg;
  logic       rst_h_reg;
  logic       rst_n_next;

  // Debounced manual level and decoded events
  logic       man_clean;
  logic       man_low;
  logic       man_fall;
  logic       kick_edge;
  logic       wd_expire;
  logic       cause;
  logic       hold_done;
  logic       hold_stay;
  logic       in_reset;
  logic       wd_clear;

  input_debounce u_deb (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .raw_in    (manual_reset_n),
    .clean_out (man_clean)
  );

  // Reset causes; an absent manual input reads as released
  assign man_low    = HAS_MANUAL && !man_clean; // [RQ3] [RQ16]
  assign man_fall   = HAS_MANUAL && man_d_reg && !man_clean; // [RQ7]
  assign cause      = supply_low || man_low; // [RQ1] [RQ3]

  // Sampled each 50 ns cycle so a single-cycle pulse is an edge
  assign kick_edge  = watchdog_kick_in != kick_d_reg; // [RQ9]
  assign wd_expire  = HAS_WATCHDOG && (wd_reg >= WDOG_CYCLES - count_t'(1)); // [RQ5]

  // Hold timer runs only while the sequencer stays in hold
  assign in_reset   = state_reg != st_run;
  assign hold_stay  = (state_reg == st_hold) && (state_next == st_hold);
  assign hold_done  = hold_reg >= RESET_HOLD_CYCLES - count_t'(1); // [RQ15]
  assign hold_next  = hold_stay ? hold_reg + count_t'(1) : '0; // [RQ15]

  // Reset, kick edge, manual press or own expiry restart the count
  assign wd_clear   = in_reset || kick_edge || man_fall || wd_expire; // [RQ6] [RQ7] [RQ8]
  assign wd_next    = (wd_clear || !HAS_WATCHDOG) ? '0 : wd_reg + count_t'(1);

  // Weak driver: low for first 7/8 of the count, high last 1/8
  assign weak_edge  = count_t'((64'(WDOG_CYCLES) * WD_LOW_EIGHTHS) / WD_EIGHTHS);
  assign weak_next  = HAS_WATCHDOG && (wd_reg >= weak_edge); // [RQ10]

  // Both reset outputs follow the sequencer's next state
  assign rst_n_next = state_next == st_run; // [RQ1] [RQ2] [RQ13]

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      st_power: begin
        if (!cause) begin
          state_next = st_hold; // [RQ2]
        end
      end
      st_hold: begin
        if (cause) begin
          state_next = st_power; // [RQ3]
        end else if (hold_done) begin
          state_next = st_run; // [RQ2] [RQ3]
        end
      end
      st_run: begin
        if (cause) begin
          state_next = st_power; // [RQ1]
        end else if (wd_expire) begin
          state_next = st_hold; // [RQ5]
        end
      end
      default: begin
        state_next = st_power;
      end
    endcase
  end

  // Sequencer and timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_reg <= st_power;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      hold_reg <= '0;
    end else begin
      hold_reg <= hold_next; // [RQ15]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_reg <= '0;
    end else begin
      wd_reg <= wd_next; // [RQ8]
    end
  end

  // Input history for edge detection
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      kick_d_reg <= 1'b0;
    end else begin
      kick_d_reg <= watchdog_kick_in; // [RQ9]
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      man_d_reg <= 1'b1;
    end else begin
      man_d_reg <= man_clean; // [RQ7]
    end
  end

  // Weak driver level and enable
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      weak_reg <= 1'b0;
    end else begin
      weak_reg <= weak_next; // [RQ10]
    end
  end

  // Enabled whenever the watchdog is built in; a driven pin wins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      weak_oe_reg <= !HAS_WATCHDOG;
    end else begin
      weak_oe_reg <= !HAS_WATCHDOG; // [RQ10] [RQ16]
    end
  end

  // Outputs, each straight from a flop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_n_reg <= 1'b0;
    end else if (OPEN_DRAIN) begin
      rst_n_reg <= 1'b0; // [RQ14]
    end else begin
      rst_n_reg <= rst_n_next; // [RQ1] [RQ2]
    end
  end

  // Open-drain style drives low only while enabled
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_n_oe_reg <= 1'b0;
    end else if (OPEN_DRAIN) begin
      rst_n_oe_reg <= rst_n_next; // [RQ14]
    end else begin
      rst_n_oe_reg <= 1'b0; // [RQ14]
    end
  end

  // Active-high copy; when not built, high during rst and low after
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rst_h_reg <= 1'b1;
    end else if (HAS_ACTIVE_HIGH) begin
      rst_h_reg <= !rst_n_next; // [RQ13]
    end else begin
      rst_h_reg <= 1'b0; // [RQ16]
    end
  end

  assign reset_n_out    = rst_n_reg;
  assign reset_n_oe_n   = rst_n_oe_reg;
  assign reset_out      = rst_h_reg;
  assign kick_weak_out  = weak_reg;
  assign kick_weak_oe_n = weak_oe_reg; // [RQ10]
endmodule : supervisor_reset_watchdog

// *** sim/sup_asserts.sv ***
`timescale 1ns/1ns
module sup_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_low,
  input wire logic manual_reset_n,
  input wire logic watchdog_kick_in,
  input wire logic kick_weak_out,
  input wire logic kick_weak_oe_n,
  input wire logic reset_n_out,
  input wire logic reset_n_oe_n,
  input wire logic reset_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  sequence held_s;
    !reset_n_out [*8];
  endsequence
  a_supply_asserts: assert property (supply_low |=> !reset_n_out && reset_out)
    else $error("reset missed low supply");
  a_supply_hold: assert property ($fell(supply_low) |-> held_s)
    else $error("reset hold too short");
  a_out_complement: assert property (reset_out == !reset_n_out)
    else $error("reset outputs disagree");
  a_pushpull_oe: assert property (reset_n_oe_n == 1'b0)
    else $error("push-pull reset released");
  a_weak_enabled: assert property (kick_weak_oe_n == 1'b0)
    else $error("weak driver off");
  a_weak_quiet: assert property (!reset_n_out [*2] |-> !kick_weak_out)
    else $error("count runs in reset");
  a_weak_rise: assert property ($rose(kick_weak_out) |-> reset_n_out)
    else $error("weak high during reset");
  a_kick_keeps: assert property ($changed(watchdog_kick_in) && reset_n_out && !supply_low
    && manual_reset_n |=> reset_n_out)
    else $error("kick did not clear count");
endmodule : sup_asserts
bind supervisor_reset_watchdog sup_asserts chk_u (
  .ref_clk          (ref_clk),
  .rst              (rst),
  .supply_low       (supply_low),
  .manual_reset_n   (manual_reset_n),
  .watchdog_kick_in (watchdog_kick_in),
  .kick_weak_out    (kick_weak_out),
  .kick_weak_oe_n   (kick_weak_oe_n),
  .reset_n_out      (reset_n_out),
  .reset_n_oe_n     (reset_n_oe_n),
  .reset_out        (reset_out)
);

// *** sim/host_model.sv ***
`timescale 1ns/1ns
module host_model (
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] mode,
  output logic            kick_drv = 1'b0,
  output logic            kick_en
);
  int unsigned cnt = 0;
  // Mode 0 floats, 1 holds low, 2 pulses high, 3 flips level, every 30 cycles
  assign kick_en = (mode != 2'h0);
  always @(posedge ref_clk) begin
    cnt <= (!reset_n || cnt == 29) ? 0 : cnt + 1;
    if (mode == 2'h3) begin
      kick_drv <= kick_drv ^ (cnt == 29);
    end else begin
      kick_drv <= (mode == 2'h2) && (cnt == 29);
    end
  end
endmodule : host_model

// *** sim/tb.sv ***
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin err_count++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb;
  import supervisor_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic supply_low = 1'b0;
  logic manual_reset_n = 1'b1;
  logic [1:0] mode = 2'h2;
  int err_count = 0;
  int samples_checked = 0;
  logic kick_weak_out, kick_weak_oe_n, reset_n_out, reset_n_oe_n, reset_out, kick_drv, kick_en;
  wire logic watchdog_kick_in = kick_en ? kick_drv : (kick_weak_oe_n ? ~kick_drv : kick_weak_out);
  always #25 ref_clk = ~ref_clk;
  supervisor_reset_watchdog #(.RESET_HOLD_CYCLES(count_t'(20)), .WDOG_CYCLES(count_t'(80)))
    dut_u (.ref_clk, .rst, .supply_low, .manual_reset_n, .watchdog_kick_in, .kick_weak_out,
    .kick_weak_oe_n, .reset_n_out, .reset_n_oe_n, .reset_out);
  host_model host_u (.ref_clk, .reset_n(reset_n_out), .mode, .kick_drv, .kick_en);
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude
  task automatic wt(input logic v, output int n);
    n = 0;
    while (reset_n_out !== v) begin
      @(negedge ref_clk);
      n++;
      if (n > 400) begin err_count++; conclude(); end
    end
  endtask : wt
  task automatic t_supply;
    int n;
    @(posedge ref_clk) supply_low <= 1'b1;
    repeat (3) @(negedge ref_clk);
    `CHK(reset_out, 1'b1)
    @(posedge ref_clk) supply_low <= 1'b0;
    wt(1'b1, n);
    `CHK(n >= 20 && n <= 23, 1'b1)
    $display("supply test done");
  endtask : t_supply
  task automatic t_manual;
    int n;
    repeat (4) begin
      @(posedge ref_clk) manual_reset_n <= ~manual_reset_n;
      repeat (5) @(posedge ref_clk);
    end
    repeat (30) @(negedge ref_clk);
    `CHK(reset_n_out, 1'b1)
    @(posedge ref_clk) manual_reset_n <= 1'b0;
    repeat (40) @(negedge ref_clk);
    `CHK(reset_n_out, 1'b0)
    @(posedge ref_clk) manual_reset_n <= 1'b1;
    wt(1'b1, n);
    `CHK(n >= 40 && n <= 46, 1'b1)
    $display("manual test done");
  endtask : t_manual
  task automatic t_wdog;
    int n;
    int lows;
    @(posedge ref_clk) mode <= 2'h1;
    wt(1'b0, n);
    `CHK(n >= 75 && n <= 85, 1'b1)
    wt(1'b1, n);
    `CHK(n >= 19 && n <= 24, 1'b1)
    for (int m = 0; m < 4; m += (m == 0) ? 2 : 1) begin
      lows = 0;
      @(posedge ref_clk) mode <= m[1:0];
      repeat (300) begin
        @(negedge ref_clk);
        if (reset_n_out !== 1'b1) lows++;
      end
      `CHK(lows, 0)
    end
    $display("watchdog test done");
  endtask : t_wdog
  task automatic t_reset;
    int n;
    repeat (5) @(posedge ref_clk);
    rst <= 1'b0;
    wt(1'b1, n);
    `CHK(n >= 19 && n <= 24, 1'b1)
    $display("reset test done");
  endtask : t_reset
  initial begin
    t_reset();
    t_supply();
    t_manual();
    t_wdog();
    conclude();
  end
endmodule : tb
